// [core/evt_entry.sv]
// CPU event entry, priority, vectoring and debug mode control
//
// Summary of operation
// RULE1 - scall and rets use the system stack
// RULE2 - debug request enters debug unless masked
// RULE3 - debug entry sets debug flag, jumps handler
// RULE4 - debug saves state in dedicated return registers
// RULE5 - mode bits writable freely while in debug
// RULE6 - debug return restores pre-debug context
// RULE7 - fetch starts at 0x80000000 after reset
// RULE8 - interrupts enter vector base plus autovector
// RULE9 - scall handler at vector base plus 0x100
// RULE10 - each exception has own fixed offset
// RULE11 - reset, debug stop, unrecoverable ranked first; the plain debug request is also taken ahead of unrecoverable
// RULE12 - data bus error outranks instruction bus error
// RULE13 - NMI at 0x10 above interrupt levels
// RULE14 - interrupt level 3 down to level 0
// RULE15 - instruction exceptions return to offending PC
// RULE16 - scall returns to call PC plus 2
// RULE17 - oldest pipeline instruction events handled first
// RULE18 - breakpoint at 0x1c, first non-completed return
// RULE19 - reset records no return address
// RULE20 - absent unit events never raised
// RULE21 - bus addresses never remapped
// RULE22 - clocks undivided on RC oscillator at start
// RULE23 - target is vector base OR offset
// RULE24 - accepted event masks equal and lower levels
// RULE25 - resolution and vector chosen in one step
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module evt_entry #(
  parameter int NSTG = evt_pkg::NUM_STAGES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pipeline event inputs, stage NSTG-1 oldest
  input wire logic [NSTG*evt_pkg::NUM_EV-1:0] ev_req,
  input wire logic [NSTG*32-1:0] stage_pc,
  input wire logic [31:0] next_pc,
  input wire logic [evt_pkg::AVEC_W-1:0] avec_offset,
  input wire logic [31:0] cur_sr,
  input wire logic dbg_req,
  input wire logic stop_req,
  input wire logic [31:0] stop_addr,
  input wire logic retd_exec,
  input wire logic rete_exec,
  input wire logic rets_exec,
  input wire logic [31:0] stack_pc,
  input wire logic [31:0] stack_sr,
  // Redirect to the fetch unit
  output logic fetch_valid,
  output logic [31:0] fetch_addr,
  output logic push_valid,
  output logic [31:0] push_pc,
  output logic [31:0] push_sr,
  output logic pop_valid,
  output logic [31:0] sr_out,
  output logic debug_active_flag,
  output logic clk_div_bypass,
  output logic ev_accepted
);
  localparam int N = evt_pkg::NUM_EV;
  localparam int SW = (NSTG > 1) ? $clog2(NSTG) : 1;

  // ------------------------------------------------------------
  // Reset synchroniser
  // ------------------------------------------------------------
  logic rs1_q, rs2_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  wire logic rst_i_n = rs2_q;

  // ------------------------------------------------------------
  // Pin synchronisers for external requests
  // ------------------------------------------------------------
  logic [1:0] dbg_s_q, stop_s_q;
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      dbg_s_q <= 2'b00;
      stop_s_q <= 2'b00;
    end else begin
      dbg_s_q <= {dbg_s_q[0], dbg_req};
      stop_s_q <= {stop_s_q[0], stop_req};
    end
  end
  wire logic dbg_sync = dbg_s_q[1];
  wire logic stop_sync = stop_s_q[1];

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [31:0] vbase_q, rsr_dbg_q, rar_dbg_q, sr_q, cause_q;
  logic first_q;

  // Absent MMU/coprocessor/FPU have no index, so none can be raised
  // [RULE20]
  function automatic logic [31:0] ev_offset(input logic [3:0] e);
    logic [31:0] o;
    o = evt_pkg::OFF_UNRECOV;
    unique case (e)
      4'h0: o = evt_pkg::OFF_UNRECOV; // [RULE11]
      4'h1: o = evt_pkg::OFF_BUS_DATA; // [RULE12]
      4'h2: o = evt_pkg::OFF_BUS_INSTR; // [RULE12]
      4'h3: o = evt_pkg::OFF_NMI; // [RULE13]
      4'h8: o = evt_pkg::OFF_INSTR_ADDR;
      4'h9: o = evt_pkg::OFF_BREAKPOINT; // [RULE18]
      4'ha: o = evt_pkg::OFF_ILLEGAL; // [RULE10]
      4'hb: o = evt_pkg::OFF_UNIMPL; // [RULE10]
      4'hc: o = evt_pkg::OFF_PRIV; // [RULE10]
      4'hd: o = evt_pkg::OFF_SCALL; // [RULE9]
      default: o = evt_pkg::OFF_UNRECOV;
    endcase
    return o;
  endfunction : ev_offset

  function automatic logic is_irq(input logic [3:0] e);
    return (e >= 4'(evt_pkg::EV_INT3)) && (e <= 4'(evt_pkg::EV_INT0));
  endfunction : is_irq

  // ------------------------------------------------------------
  // Event masking and selection
  // ------------------------------------------------------------
  // Critical events ignore the masks [RULE24]
  logic [N-1:0] ev_maskok;
  always_comb begin
    ev_maskok = '1;
    for (int l = 0; l < 4; l++) begin
      ev_maskok[evt_pkg::EV_INT0 - l] = !sr_q[evt_pkg::SR_I0M + l]
        && !sr_q[evt_pkg::SR_GM];
    end
    for (int e = evt_pkg::EV_INSTR_ADDR; e < N; e++) begin
      if (e != evt_pkg::EV_SCALL && e != evt_pkg::EV_BREAKPOINT) begin
        ev_maskok[e] = !sr_q[evt_pkg::SR_EM];
      end
    end
  end
  logic [NSTG*N-1:0] ev_eff;
  genvar g;
  generate
    for (g = 0; g < NSTG; g++) begin : g_mask
      assign ev_eff[g*N +: N] = ev_req[g*N +: N] & ev_maskok;
    end
  endgenerate

  logic pr_found;
  logic [SW-1:0] pr_stage;
  logic [3:0] pr_idx;
  evt_prio #(.N(N), .S(NSTG)) u_prio (
    .ev_stage(ev_eff),
    .found(pr_found),
    .stage(pr_stage),
    .idx(pr_idx)
  ); // [RULE17] [RULE11] [RULE14]

  wire logic [31:0] off_sel = is_irq(pr_idx)
    ? {{(32 - evt_pkg::AVEC_W){1'b0}}, avec_offset} // [RULE8]
    : ev_offset(pr_idx);
  wire logic [31:0] ev_target = vbase_q | off_sel; // [RULE23]
  wire logic [31:0] off_pc = stage_pc[pr_stage*32 +: 32];
  // Return address choice [RULE15] [RULE16] [RULE12] [RULE13]
  wire logic ret_offending = (pr_idx == 4'(evt_pkg::EV_UNRECOV))
    || (pr_idx >= 4'(evt_pkg::EV_ILLEGAL))
    || (pr_idx == 4'(evt_pkg::EV_INSTR_ADDR));
  wire logic [31:0] ev_ret = (pr_idx == 4'(evt_pkg::EV_SCALL))
    ? off_pc + evt_pkg::SCALL_RET_INC
    : (ret_offending ? off_pc : next_pc);

  wire logic in_debug = sr_q[evt_pkg::SR_DEBUG];
  // Debug stop outranks all but reset; plain request is maskable
  wire logic take_stop = stop_sync && !in_debug; // [RULE11]
  wire logic take_dbg = dbg_sync && !in_debug
    && !sr_q[evt_pkg::SR_DMASK]; // [RULE2]
  wire logic take_ev = pr_found && !take_stop && !take_dbg && !first_q;

  // New status on event acceptance [RULE24]
  logic [31:0] sr_ev;
  always_comb begin
    sr_ev = sr_q;
    if (is_irq(pr_idx)) begin
      for (int l = 0; l < 4; l++) begin
        if (4'(evt_pkg::EV_INT0 - l) >= pr_idx) begin
          sr_ev[evt_pkg::SR_I0M + l] = 1'b1;
        end
      end
      sr_ev[evt_pkg::SR_MODE_HI:evt_pkg::SR_MODE_LO] =
        evt_pkg::MODE_INT0 + 3'(evt_pkg::EV_INT0 - pr_idx);
    end else if (pr_idx == 4'(evt_pkg::EV_SCALL)) begin
      sr_ev[evt_pkg::SR_MODE_HI:evt_pkg::SR_MODE_LO] = evt_pkg::MODE_SUP;
    end else begin
      sr_ev[evt_pkg::SR_EM] = 1'b1;
      sr_ev[evt_pkg::SR_GM] = 1'b1;
      for (int l = 0; l < 4; l++) begin
        sr_ev[evt_pkg::SR_I0M + l] = 1'b1;
      end
      sr_ev[evt_pkg::SR_MODE_HI:evt_pkg::SR_MODE_LO] =
        (pr_idx == 4'(evt_pkg::EV_NMI)) ? evt_pkg::MODE_NMI
                                        : evt_pkg::MODE_EXC;
    end
  end

  // Debug entry: exception context, global mask raised, flag set [RULE3]
  logic [31:0] sr_dbg;
  always_comb begin
    sr_dbg = sr_q;
    sr_dbg[evt_pkg::SR_DEBUG] = 1'b1;
    sr_dbg[evt_pkg::SR_GM] = 1'b1;
    sr_dbg[evt_pkg::SR_MODE_HI:evt_pkg::SR_MODE_LO] = evt_pkg::MODE_EXC;
  end

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire logic apb_acc = psel && penable;
  wire logic apb_wr = apb_acc && pwrite;
  wire logic hit_sr = paddr == evt_pkg::A_STATUS;
  wire logic hit_vb = paddr == evt_pkg::A_VBASE;
  wire logic hit_rsr = paddr == evt_pkg::A_RSR_DBG;
  wire logic hit_rar = paddr == evt_pkg::A_RAR_DBG;
  wire logic hit_cause = paddr == evt_pkg::A_CAUSE;
  wire logic hit_any = hit_sr || hit_vb || hit_rsr || hit_rar || hit_cause;
  // Mode bits only writable from software while in debug [RULE5]
  wire logic [31:0] sr_wmask = in_debug ? 32'hffff_ffff
    : ~(32'h0000_0007 << evt_pkg::SR_MODE_LO);
  wire logic [31:0] sr_sw = (sr_q & ~sr_wmask) | (pwdata & sr_wmask);
  wire logic [31:0] rd_mux = hit_sr ? sr_q : hit_vb ? vbase_q
    : hit_rsr ? rsr_dbg_q : hit_rar ? rar_dbg_q
    : hit_cause ? cause_q : 32'h0000_0000;

  // ------------------------------------------------------------
  // Main sequencing, all in one step per event [RULE25]
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      sr_q <= evt_pkg::SR_RESET;
      vbase_q <= 32'h0000_0000;
      rsr_dbg_q <= 32'h0000_0000;
      rar_dbg_q <= 32'h0000_0000; // Reset leaves no return [RULE19]
      cause_q <= 32'h0000_0000;
      first_q <= 1'b1;
      fetch_valid <= 1'b0;
      fetch_addr <= evt_pkg::RESET_ADDR;
      push_valid <= 1'b0;
      push_pc <= 32'h0000_0000;
      push_sr <= 32'h0000_0000;
      pop_valid <= 1'b0;
      ev_accepted <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      fetch_valid <= 1'b0;
      push_valid <= 1'b0;
      pop_valid <= 1'b0;
      ev_accepted <= 1'b0;
      pready <= psel && !pready;
      pslverr <= psel && !pready && !hit_any;
      prdata <= rd_mux;
      if (apb_wr && pready && hit_vb) vbase_q <= pwdata;
      if (apb_wr && pready && hit_sr) sr_q <= sr_sw;
      if (first_q) begin
        first_q <= 1'b0;
        fetch_valid <= 1'b1;
        fetch_addr <= evt_pkg::RESET_ADDR; // [RULE7] [RULE21]
      end else if (take_stop || take_dbg) begin
        rar_dbg_q <= next_pc; // [RULE4]
        rsr_dbg_q <= sr_q;
        sr_q <= sr_dbg;
        fetch_valid <= 1'b1;
        fetch_addr <= take_stop ? stop_addr
          : vbase_q | evt_pkg::OFF_BREAKPOINT; // [RULE3]
      end else if (retd_exec && in_debug) begin
        sr_q <= rsr_dbg_q; // [RULE6]
        fetch_valid <= 1'b1;
        fetch_addr <= rar_dbg_q;
      end else if (rete_exec || rets_exec) begin
        sr_q <= stack_sr; // [RULE1]
        pop_valid <= 1'b1;
        fetch_valid <= 1'b1;
        fetch_addr <= stack_pc;
      end else if (take_ev) begin
        sr_q <= sr_ev;
        push_valid <= 1'b1; // [RULE1]
        push_pc <= ev_ret;
        push_sr <= sr_q;
        fetch_valid <= 1'b1;
        fetch_addr <= ev_target;
        cause_q <= {28'h0000000, pr_idx};
        ev_accepted <= 1'b1;
      end
    end
  end

  // Clock tree left undivided on the RC oscillator until software
  // reconfigures it elsewhere [RULE22]
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) clk_div_bypass <= 1'b1;
    else clk_div_bypass <= 1'b1;
  end

  assign sr_out = sr_q;
  assign debug_active_flag = sr_q[evt_pkg::SR_DEBUG];

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_i_n);

  AST_DBG_MASK: assert property ( // [RULE2]
    (dbg_sync && sr_q[evt_pkg::SR_DMASK] && !stop_sync && !in_debug)
    |=> !sr_q[evt_pkg::SR_DEBUG] || $past(in_debug)
  ) else $error("Masked debug request entered debug");
  // A stop in the same cycle redirects to its own target instead
  AST_DBG_ENTRY: assert property ( // [RULE3]
    (take_dbg && !take_stop && !first_q) |=> in_debug && fetch_valid
      && fetch_addr == ($past(vbase_q) | evt_pkg::OFF_BREAKPOINT)
  ) else $error("Debug entry wrong");
  AST_DBG_SAVE: assert property ( // [RULE4]
    (take_dbg && !first_q) |=> rar_dbg_q == $past(next_pc) && !push_valid
  ) else $error("Debug save wrong");
  AST_RETD: assert property ( // [RULE6]
    (retd_exec && in_debug && !take_stop && !first_q)
    |=> sr_q == $past(rsr_dbg_q) && fetch_addr == $past(rar_dbg_q)
  ) else $error("Debug return wrong");
  AST_OR_TARGET: assert property ( // [RULE23]
    ev_accepted |-> (fetch_addr & ~$past(vbase_q)) == ($past(off_sel)
      & ~$past(vbase_q))
  ) else $error("Target not formed by OR");
  AST_SCALL_RET: assert property ( // [RULE16]
    (take_ev && pr_idx == 4'(evt_pkg::EV_SCALL) && !retd_exec
      && !rete_exec && !rets_exec)
    |=> push_pc == $past(off_pc) + evt_pkg::SCALL_RET_INC
  ) else $error("Scall return address wrong");
  AST_IRQ_MASK: assert property ( // [RULE24]
    (ev_accepted && $past(is_irq(pr_idx)))
    |-> sr_q[evt_pkg::SR_I0M + evt_pkg::EV_INT0 - $past(pr_idx)]
  ) else $error("Interrupt level not masked");
  AST_PUSH_FETCH: assert property ( // [RULE25]
    push_valid |-> fetch_valid && ev_accepted
  ) else $error("Push without redirect");

  COV_IRQ: cover property (ev_accepted && sr_q[evt_pkg::SR_I3M]);
  COV_DBG: cover property (take_dbg ##[1:50] retd_exec);
  COV_SCALL: cover property (take_ev && pr_idx == 4'(evt_pkg::EV_SCALL));
endmodule : evt_entry
`default_nettype wire

// [core/evt_pkg.sv]
// Constants for the CPU event entry and debug mode unit
package evt_pkg;
  localparam logic [31:0] RESET_ADDR = 32'h8000_0000;
  localparam int AVEC_W = 14;
  localparam logic [31:0] OFF_UNRECOV = 32'h0000_0000;
  localparam logic [31:0] OFF_BUS_DATA = 32'h0000_0008;
  localparam logic [31:0] OFF_BUS_INSTR = 32'h0000_000c;
  localparam logic [31:0] OFF_NMI = 32'h0000_0010;
  localparam logic [31:0] OFF_INSTR_ADDR = 32'h0000_0014;
  localparam logic [31:0] OFF_BREAKPOINT = 32'h0000_001c;
  localparam logic [31:0] OFF_ILLEGAL = 32'h0000_0020;
  localparam logic [31:0] OFF_UNIMPL = 32'h0000_0024;
  localparam logic [31:0] OFF_PRIV = 32'h0000_0028;
  localparam logic [31:0] OFF_SCALL = 32'h0000_0100;
  localparam logic [31:0] OFF_DADDR_RD = 32'h0000_0034;
  localparam logic [31:0] OFF_DADDR_WR = 32'h0000_0038;
  localparam logic [31:0] SCALL_RET_INC = 32'h0000_0002;
  // APB register byte addresses
  localparam logic [11:0] A_STATUS = 12'h000;
  localparam logic [11:0] A_VBASE = 12'h004;
  localparam logic [11:0] A_RSR_DBG = 12'h030;
  localparam logic [11:0] A_RAR_DBG = 12'h050;
  localparam logic [11:0] A_CAUSE = 12'h010;
  // Status word bits
  localparam int SR_GM = 16;
  localparam int SR_I0M = 17;
  localparam int SR_I3M = 20;
  localparam int SR_EM = 21;
  localparam int SR_MODE_LO = 22;
  localparam int SR_MODE_HI = 24;
  localparam int SR_DEBUG = 26;
  localparam int SR_DMASK = 27;
  localparam logic [31:0] SR_RESET = 32'h0021_0000 | 32'h0040_0000;
  localparam logic [2:0] MODE_SUP = 3'h1;
  localparam logic [2:0] MODE_INT0 = 3'h2;
  localparam logic [2:0] MODE_EXC = 3'h6;
  localparam logic [2:0] MODE_NMI = 3'h7;
  localparam int NUM_EV = 14;
  // Event index, lower index wins
  localparam int EV_UNRECOV = 0;
  localparam int EV_BUS_DATA = 1;
  localparam int EV_BUS_INSTR = 2;
  localparam int EV_NMI = 3;
  localparam int EV_INT3 = 4;
  localparam int EV_INT0 = 7;
  localparam int EV_INSTR_ADDR = 8;
  localparam int EV_BREAKPOINT = 9;
  localparam int EV_ILLEGAL = 10;
  localparam int EV_UNIMPL = 11;
  localparam int EV_PRIV = 12;
  localparam int EV_SCALL = 13;
  localparam int NUM_STAGES = 2;
endpackage : evt_pkg

// [core/evt_prio.sv]
// Fixed-priority picker with per-stage oldest-first selection
`timescale 1ns/1ps
`default_nettype none
module evt_prio #(
  parameter int N = 14,
  parameter int S = 2
) (
  input wire logic [S*N-1:0] ev_stage,
  output logic found,
  output logic [$clog2(S)-1:0] stage,
  output logic [$clog2(N)-1:0] idx
);
  // Stage S-1 is oldest and wins regardless of younger priorities
  always_comb begin
    found = 1'b0;
    stage = '0;
    idx = '0;
    for (int s = 0; s < S; s++) begin
      for (int i = N - 1; i >= 0; i--) begin
        if (ev_stage[s*N+i]) begin
          found = 1'b1;
          stage = s[$clog2(S)-1:0];
          idx = i[$clog2(N)-1:0];
        end
      end
      // Inner loop leaves the highest priority; outer keeps the oldest
    end
  end
endmodule : evt_prio
`default_nettype wire

// [bench/evt_irq_model.sv]
// Interrupt controller model: level requests and autovector offsets
`timescale 1ns/1ps
`default_nettype none
module evt_irq_model #(
  parameter logic [13:0] AVEC_BASE = 14'h3f00
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] raise,
  input wire logic ev_accepted,
  input wire logic [31:0] fetch_addr,
  input wire logic [31:0] vbase,
  output logic [3:0] int_pend,
  output logic [13:0] avec_offset
);
  logic [3:0] pend_q;
  logic [1:0] top;
  logic [13:0] off;
  logic taken;
  assign top = pend_q[3] ? 2'h3 : pend_q[2] ? 2'h2 : pend_q[1] ? 2'h1 : 2'h0;
  // One offset per level, all inside the 14-bit autovector range
  assign off = AVEC_BASE | {6'h0, top, 6'h0};
  // A level stays pending until the core is seen entering its vector
  assign taken = ev_accepted && (fetch_addr == (vbase | {18'h0, off}));
  assign int_pend = pend_q;
  // Idle offset lines mean nothing, so they do not hold the last value
  assign avec_offset = (pend_q != 4'h0) ? off : ~off;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 4'h0;
    end else begin
      pend_q <= (pend_q | raise) & ~(taken ? (4'h1 << top) : 4'h0);
    end
  end
endmodule : evt_irq_model
`default_nettype wire

// [bench/tb.sv]
// Self-checking testbench for the CPU event entry unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [13:0] AVEC_BASE = 14'h3f00;
  // Low bits overlap the offsets, so OR and add give different targets
  localparam logic [31:0] VBASE = 32'h8000_4104;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, next_pc, stop_addr, stack_pc, stack_sr, rd;
  logic [27:0] ev_req;
  logic [13:0] ev_x0, ev_x1, avec_offset;
  logic [63:0] stage_pc;
  logic dbg_req, stop_req, retd_exec, rete_exec, rets_exec;
  logic fetch_valid, push_valid, pop_valid, debug_active_flag;
  logic clk_div_bypass, ev_accepted;
  logic [31:0] fetch_addr, push_pc, push_sr, sr_out;
  logic [3:0] raise, int_pend;
  logic [4:0] m;
  int bad_count, n_tests, a, b, nf;
  int push_cnt = 0;
  int evs[10] = '{0, 1, 2, 3, 8, 9, 10, 11, 12, 13};
  assign ev_req = {ev_x1, ev_x0 | {6'h0, int_pend[0], int_pend[1],
                   int_pend[2], int_pend[3], 4'h0}};
  evt_entry DUT (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ev_req, .stage_pc, .next_pc,
    .avec_offset, .cur_sr(sr_out), .dbg_req, .stop_req, .stop_addr,
    .retd_exec, .rete_exec, .rets_exec, .stack_pc, .stack_sr, .fetch_valid,
    .fetch_addr, .push_valid, .push_pc, .push_sr, .pop_valid, .sr_out,
    .debug_active_flag, .clk_div_bypass, .ev_accepted);
  evt_irq_model #(.AVEC_BASE(AVEC_BASE)) irq (.sys_clk, .rst_n, .raise,
    .ev_accepted, .fetch_addr, .vbase(VBASE), .int_pend, .avec_offset);
  always @(posedge sys_clk) if (push_valid === 1'b1) push_cnt <= push_cnt + 1;
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // Checking and bus helpers
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      bad_count++;
      $display("mismatch %0t word %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic chk_bit(input logic g, input logic x);
    n_tests++;
    if (g !== x) begin
      bad_count++;
      $display("mismatch %0t flag %b expected %b", $time, g, x);
    end
  endtask : chk_bit
  // Sel 0 acceptance, 1 pop, 2 fetch redirect; a hang ends the run
  task automatic wait_for(input int k);
    for (int i = 0; i < 16; i++) begin
      if ((k == 0 && ev_accepted === 1'b1) || (k == 1 && pop_valid === 1'b1)
          || (k == 2 && fetch_valid === 1'b1)) return;
      @(posedge sys_clk);
      #1;
    end
    bad_count++;
    $display("mismatch %0t wait ran out", $time);
    close_out();
  endtask : wait_for
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) begin
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        return;
      end
    end
    bad_count++;
    $display("mismatch %0t bus wait ran out", $time);
    close_out();
  endtask : apb
  // ----------------------------------------------------------------
  // Expectations and event sequences
  // ----------------------------------------------------------------
  function automatic logic [31:0] exp_off(input int i);
    case (i)
      0: return evt_pkg::OFF_UNRECOV;
      1: return evt_pkg::OFF_BUS_DATA;
      2: return evt_pkg::OFF_BUS_INSTR;
      3: return evt_pkg::OFF_NMI;
      8: return evt_pkg::OFF_INSTR_ADDR;
      9: return evt_pkg::OFF_BREAKPOINT;
      10: return evt_pkg::OFF_ILLEGAL;
      11: return evt_pkg::OFF_UNIMPL;
      12: return evt_pkg::OFF_PRIV;
      default: return evt_pkg::OFF_SCALL;
    endcase
  endfunction : exp_off
  function automatic logic [31:0] exp_ret(input int i, input logic [31:0] pc);
    if (i == 13) return pc + evt_pkg::SCALL_RET_INC;
    if (i inside {1, 2, 3, 9}) return next_pc;
    return pc;
  endfunction : exp_ret
  task automatic ret_back(input logic use_rets);
    logic [31:0] t;
    t = $urandom();
    @(posedge sys_clk);
    rets_exec <= use_rets;
    rete_exec <= ~use_rets;
    stack_pc <= t;
    @(posedge sys_clk);
    rets_exec <= 1'b0;
    rete_exec <= 1'b0;
    #1;
    wait_for(1);
    chk(fetch_addr, t);
    chk(sr_out, 32'h0);
  endtask : ret_back
  task automatic fire(input logic [13:0] b1, input logic [13:0] b0);
    @(posedge sys_clk);
    ev_x1 <= b1;
    ev_x0 <= b0;
    next_pc <= $urandom();
    stage_pc <= {$urandom(), $urandom()};
    @(posedge sys_clk);
    ev_x1 <= '0;
    ev_x0 <= '0;
    #1;
    wait_for(0);
  endtask : fire
  task automatic chk_evt(input int i, input int s);
    logic [31:0] pc;
    pc = (s == 1) ? stage_pc[63:32] : stage_pc[31:0];
    chk(fetch_addr, VBASE | exp_off(i));
    chk(push_pc, exp_ret(i, pc));
    chk(push_sr, 32'h0);
    ret_back(i == 13);
  endtask : chk_evt
  // Lower index wins on one instruction; split puts y on the oldest one
  task automatic pair(input int x, input int y, input logic split);
    if (split) begin
      fire(14'h1 << y, 14'h1 << x);
      chk_evt(y, 1);
    end else begin
      fire(14'h0, (14'h1 << x) | (14'h1 << y));
      chk_evt(x, 0);
    end
  endtask : pair
  task automatic leave_dbg;
    repeat (4) @(posedge sys_clk);
    retd_exec <= 1'b1;
    @(posedge sys_clk);
    retd_exec <= 1'b0;
    #1;
    wait_for(2);
    chk(fetch_addr, next_pc);
    chk(sr_out, 32'h0);
    chk_bit(debug_active_flag, 1'b0);
  endtask : leave_dbg
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, dbg_req, stop_req} = '0;
    {retd_exec, rete_exec, rets_exec, raise, paddr, pwdata} = '0;
    {next_pc, stop_addr, stack_pc, stack_sr, ev_x0, ev_x1, stage_pc} = '0;
    bad_count = 0;
    n_tests = 0;
    void'($urandom(43));
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    wait_for(2);
    chk(fetch_addr, evt_pkg::RESET_ADDR);
    chk_bit(push_valid, 1'b0);
    chk_bit(clk_div_bypass, 1'b1);
    repeat (4) @(posedge sys_clk);
    apb(1'b0, evt_pkg::A_STATUS, 32'h0);
    chk(rd, evt_pkg::SR_RESET);
    apb(1'b1, evt_pkg::A_VBASE, VBASE);
    apb(1'b0, evt_pkg::A_VBASE, 32'h0);
    chk(rd, VBASE);
    apb(1'b0, 12'hffc, 32'h0);
    chk_bit(e, 1'b1);
    ret_back(1'b0);
    for (int k = 0; k < 10; k++) pair(evs[k], evs[k], 1'b0);
    pair(1, 2, 1'b0);
    pair(0, 13, 1'b1);
    for (int k = 0; k < 12; k++) begin
      a = $urandom_range(9, 0);
      b = (a + 1 + $urandom_range(8, 0)) % 10;
      pair(evs[a < b ? a : b], evs[a < b ? b : a],
           $urandom_range(1, 0));
    end
    // NMI and all four levels together, then the levels one by one
    @(posedge sys_clk);
    raise <= 4'hf;
    next_pc <= $urandom();
    @(posedge sys_clk);
    raise <= 4'h0;
    ev_x0 <= 14'h1 << evt_pkg::EV_NMI;
    @(posedge sys_clk);
    ev_x0 <= '0;
    #1;
    wait_for(0);
    chk(fetch_addr, VBASE | evt_pkg::OFF_NMI);
    chk(push_pc, next_pc);
    ret_back(1'b0);
    for (int l = 3; l >= 0; l--) begin
      wait_for(0);
      m = (5'h2 << l) - 5'h1;
      chk(fetch_addr, VBASE | 32'(AVEC_BASE | 14'(l << 6)));
      chk(push_pc, next_pc);
      chk({28'h0, sr_out[20:17] & m[3:0]}, {28'h0, m[3:0]});
      ret_back(1'b0);
    end
    // Debug entry, state registers, free mode writes and return
    // Let the redirect of the last return pass before waiting for entry
    nf = push_cnt;
    @(posedge sys_clk);
    dbg_req <= 1'b1;
    #1;
    wait_for(2);
    @(posedge sys_clk);
    dbg_req <= 1'b0;
    chk(fetch_addr, VBASE | evt_pkg::OFF_BREAKPOINT);
    chk_bit(debug_active_flag, 1'b1);
    chk_bit(sr_out[evt_pkg::SR_DEBUG], 1'b1);
    chk(push_cnt, nf);
    apb(1'b0, evt_pkg::A_RAR_DBG, 32'h0);
    chk(rd, next_pc);
    apb(1'b0, evt_pkg::A_RSR_DBG, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, evt_pkg::A_STATUS, 32'h0480_0000);
    apb(1'b0, evt_pkg::A_STATUS, 32'h0);
    chk(rd & 32'h01c0_0000, 32'(evt_pkg::MODE_INT0) << 22);
    leave_dbg();
    apb(1'b1, evt_pkg::A_STATUS, 32'h1 << evt_pkg::SR_DMASK);
    nf = 0;
    dbg_req <= 1'b1;
    repeat (12) begin
      @(posedge sys_clk);
      #1;
      if (fetch_valid === 1'b1) nf++;
    end
    @(posedge sys_clk);
    dbg_req <= 1'b0;
    chk(nf, 0);
    chk_bit(debug_active_flag, 1'b0);
    repeat (4) @(posedge sys_clk);
    apb(1'b1, evt_pkg::A_STATUS, 32'h0);
    stop_addr <= $urandom();
    stop_req <= 1'b1;
    wait_for(2);
    @(posedge sys_clk);
    stop_req <= 1'b0;
    chk(fetch_addr, stop_addr);
    chk_bit(debug_active_flag, 1'b1);
    leave_dbg();
    close_out();
  end
endmodule : tb
`default_nettype wire
